//--- src/smsp_port.sv
// serial port master/slave with axi4-lite register access
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module smsp_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [smsp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [smsp_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire smsp_pkg::smsp_pin_in_s pinIn,
  output smsp_pkg::smsp_pin_out_s pinOut,
  output logic irq
);
  // bus slave state
  logic awPend_q;
  logic [smsp_pkg::ADDR_W-1:0] awAddr_q;
  logic wPend_q;
  logic [7:0] wData_q;
  logic wLane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;
  // registers
  logic [7:0] ctl_q;
  logic doneFlag_q;
  logic collFlag_q;
  logic [7:0] rxData_q;
  logic [smsp_pkg::EVT_W-1:0] evtSts_q;
  logic [smsp_pkg::EVT_W-1:0] evtMask_q;
  logic serialIe_q;
  // engine
  smsp_pkg::smsp_state_e state_q;
  logic [6:0] halfCnt_q;
  logic [4:0] edgeCnt_q;
  logic sclk_q;
  logic sclkPrev_q;

  // write decode
  logic wrFire;
  logic wrCtl;
  logic wrSts;
  logic wrData;
  logic wrMask;
  logic wrSie;
  logic wrMapped;
  assign wrFire = awPend_q & wPend_q & ~bvalid_q;
  assign wrCtl = wrFire & wLane_q & (awAddr_q == smsp_pkg::CONTROL_ADDR);
  assign wrSts = wrFire & wLane_q & (awAddr_q == smsp_pkg::STATUS_ADDR);
  assign wrData = wrFire & wLane_q & (awAddr_q == smsp_pkg::DATA_ADDR);
  assign wrMask = wrFire & wLane_q & (awAddr_q == smsp_pkg::EVT_MASK_ADDR);
  assign wrSie = wrFire & wLane_q & (awAddr_q == smsp_pkg::SERIAL_IE_ADDR);
  assign wrMapped = (awAddr_q == smsp_pkg::CONTROL_ADDR) | (awAddr_q == smsp_pkg::STATUS_ADDR) |
                    (awAddr_q == smsp_pkg::DATA_ADDR) | (awAddr_q == smsp_pkg::EVT_MASK_ADDR) |
                    (awAddr_q == smsp_pkg::SERIAL_IE_ADDR) | (awAddr_q == smsp_pkg::EVT_STATUS_ADDR);

  // read decode
  logic rdFire;
  logic rdEvtSts;
  logic rdHit;
  logic [7:0] rdMux;
  logic [7:0] stsByte;
  assign rdFire = s_axi_arvalid & ~rvalid_q;
  assign rdEvtSts = rdFire & (s_axi_araddr == smsp_pkg::EVT_STATUS_ADDR);
  assign stsByte = {doneFlag_q, collFlag_q, 6'h00};
  assign rdHit = (s_axi_araddr == smsp_pkg::CONTROL_ADDR) | (s_axi_araddr == smsp_pkg::STATUS_ADDR) |
                 (s_axi_araddr == smsp_pkg::DATA_ADDR) | (s_axi_araddr == smsp_pkg::EVT_MASK_ADDR) |
                 (s_axi_araddr == smsp_pkg::SERIAL_IE_ADDR) | (s_axi_araddr == smsp_pkg::EVT_STATUS_ADDR);
  assign rdMux = (s_axi_araddr == smsp_pkg::CONTROL_ADDR) ? ctl_q :
                 (s_axi_araddr == smsp_pkg::STATUS_ADDR) ? stsByte :
                 (s_axi_araddr == smsp_pkg::DATA_ADDR) ? rxData_q :
                 (s_axi_araddr == smsp_pkg::EVT_STATUS_ADDR) ? {6'h00, evtSts_q} :
                 (s_axi_araddr == smsp_pkg::EVT_MASK_ADDR) ? {6'h00, evtMask_q} :
                 (s_axi_araddr == smsp_pkg::SERIAL_IE_ADDR) ? {7'h00, serialIe_q} : 8'h00;

  assign s_axi_awready = ~awPend_q;
  assign s_axi_wready = ~wPend_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;

  // address and data are held separately, so either may arrive first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      awPend_q <= 1'b0;
      awAddr_q <= '0;
    end else if (s_axi_awvalid & ~awPend_q) begin
      awPend_q <= 1'b1;
      awAddr_q <= s_axi_awaddr;
    end else if (wrFire) begin
      awPend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wPend_q <= 1'b0;
      wData_q <= 8'h00;
      wLane_q <= 1'b0;
    end else if (s_axi_wvalid & ~wPend_q) begin
      wPend_q <= 1'b1;
      wData_q <= s_axi_wdata[7:0];
      wLane_q <= s_axi_wstrb[0];
    end else if (wrFire) begin
      wPend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= smsp_pkg::RESP_OKAY;
    end else if (wrFire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wrMapped ? smsp_pkg::RESP_OKAY : smsp_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= smsp_pkg::RESP_OKAY;
    end else if (rdFire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdMux;
      rresp_q <= rdHit ? smsp_pkg::RESP_OKAY : smsp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // control fields
  logic enabled;
  logic isMaster;
  logic clock_idle_polarity;
  logic clock_shift_phase;
  logic lsbFirst;
  logic [1:0] rateSel;
  logic [6:0] halfSel;
  assign enabled = ctl_q[smsp_pkg::CTL_ENABLE_BIT];
  assign isMaster = ctl_q[smsp_pkg::CTL_ROLE_BIT];
  assign clock_idle_polarity = ctl_q[smsp_pkg::CTL_CLOCK_IDLE_POLARITY_BIT];
  assign clock_shift_phase = ctl_q[smsp_pkg::CTL_CLOCK_SHIFT_PHASE_BIT];
  assign lsbFirst = ctl_q[smsp_pkg::CTL_ORDER_BIT];
  assign rateSel = {ctl_q[smsp_pkg::CTL_RATE_HI_BIT], ctl_q[smsp_pkg::CTL_RATE_LO_BIT]};
  assign halfSel = (rateSel == 2'h0) ? smsp_pkg::HALF_RATE0 :
                   (rateSel == 2'h1) ? smsp_pkg::HALF_RATE1 :
                   (rateSel == 2'h2) ? smsp_pkg::HALF_RATE2 : smsp_pkg::HALF_RATE3;

  // engine decode
  logic masterTick;
  logic slaveSel;
  logic slaveEdge;
  logic edgeEv;
  logic leading;
  logic trailing;
  logic sampleEn;
  logic driveEn;
  logic xferDone;
  logic busy;
  logic startLoad;
  logic startMaster;
  logic collision;
  logic inBit;
  logic txBit;
  logic [7:0] byteOut;
  assign masterTick = (state_q == smsp_pkg::ST_MASTER) & (halfCnt_q == halfSel - 7'h01);
  assign slaveSel = enabled & ~isMaster & ~pinIn.ssN;
  assign slaveEdge = (state_q == smsp_pkg::ST_SLAVE) & (pinIn.sclk != sclkPrev_q);
  assign edgeEv = masterTick | slaveEdge;
  assign leading = edgeEv & ~edgeCnt_q[0];
  assign trailing = edgeEv & edgeCnt_q[0];
  assign sampleEn = clock_shift_phase ? trailing : leading;
  assign driveEn = clock_shift_phase ? leading : trailing;
  assign xferDone = trailing & (edgeCnt_q == smsp_pkg::LAST_EDGE);
  // a selected slave counts as busy only once its first clock edge has arrived
  assign busy = (state_q == smsp_pkg::ST_MASTER) | ((state_q == smsp_pkg::ST_SLAVE) & (edgeCnt_q != 5'h00));
  assign startLoad = wrData & ~busy;
  assign startMaster = startLoad & enabled & isMaster;
  assign collision = wrData & busy;
  assign inBit = isMaster ? pinIn.miso : pinIn.mosi;

  smsp_shifter u_shifter (
    .core_clk(core_clk),
    .rst(rst),
    .load(startLoad),
    .loadByte(wData_q),
    .lsbFirst(lsbFirst),
    .sampleEn(sampleEn),
    .driveEn(driveEn),
    .inBit(inBit),
    .byteOut(byteOut),
    .txBit(txBit)
  );

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= smsp_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        smsp_pkg::ST_IDLE: begin
          if (startMaster) begin
            state_q <= smsp_pkg::ST_MASTER;
          end else if (slaveSel) begin
            state_q <= smsp_pkg::ST_SLAVE;
          end
        end
        smsp_pkg::ST_MASTER: begin
          if (xferDone | ~enabled) begin
            state_q <= smsp_pkg::ST_IDLE;
          end
        end
        smsp_pkg::ST_SLAVE: begin
          if (xferDone | ~slaveSel) begin
            state_q <= smsp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || startMaster || masterTick) begin
      halfCnt_q <= 7'h00;
    end else if (state_q == smsp_pkg::ST_MASTER) begin
      halfCnt_q <= halfCnt_q + 7'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || state_q == smsp_pkg::ST_IDLE || xferDone) begin
      edgeCnt_q <= 5'h00;
    end else if (edgeEv) begin
      edgeCnt_q <= edgeCnt_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclk_q <= 1'b0;
    end else if (state_q != smsp_pkg::ST_MASTER) begin
      sclk_q <= clock_idle_polarity;
    end else if (masterTick) begin
      sclk_q <= ~sclk_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
    end else begin
      sclkPrev_q <= pinIn.sclk;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_q <= smsp_pkg::CONTROL_RESET;
      evtMask_q <= smsp_pkg::EVT_MASK_RESET;
      serialIe_q <= smsp_pkg::SERIAL_IE_RESET;
    end else begin
      if (wrCtl) begin
        ctl_q <= wData_q;
      end
      if (wrMask) begin
        evtMask_q <= wData_q[smsp_pkg::EVT_W-1:0];
      end
      if (wrSie) begin
        serialIe_q <= wData_q[0];
      end
    end
  end

  // collision flag sticky
  // writing zero to a flag clears it; a same-cycle set still wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      doneFlag_q <= 1'b0;
      collFlag_q <= 1'b0;
    end else begin
      doneFlag_q <= xferDone | (doneFlag_q & ~(wrSts & ~wData_q[smsp_pkg::STS_DONE_BIT]));
      collFlag_q <= collision | (collFlag_q & ~(wrSts & ~wData_q[smsp_pkg::STS_COLL_BIT]));
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rxData_q <= smsp_pkg::DATA_RESET;
    end else if (xferDone) begin
      rxData_q <= byteOut;
    end
  end

  // event status clears on read, set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      evtSts_q <= '0;
    end else begin
      evtSts_q <= {collision, xferDone} | (evtSts_q & {smsp_pkg::EVT_W{~rdEvtSts}});
    end
  end

  assign irq = ctl_q[smsp_pkg::CTL_IRQ_EN_BIT] & serialIe_q & (|(evtSts_q & evtMask_q));

  always_comb begin
    pinOut.sclk = (state_q == smsp_pkg::ST_MASTER) ? sclk_q : clock_idle_polarity;
    pinOut.mosi = txBit;
    pinOut.miso = txBit;
    pinOut.sclkOeN = ~(enabled & isMaster);
    pinOut.mosiOeN = ~(enabled & isMaster);
    pinOut.misoOeN = ~slaveSel;
  end
endmodule

//--- common/smsp_pkg.sv
// shared constants, types and register map of the serial port
package smsp_pkg;
  localparam int ADDR_W = 12;
  // printed register offsets are indices; byte address is four times the index
  localparam logic [ADDR_W-3:0] STATUS_IDX = 10'h0aa;
  localparam logic [ADDR_W-3:0] CONTROL_IDX = 10'h0d5;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] CONTROL_ADDR = {CONTROL_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] DATA_ADDR = 12'h380;
  localparam logic [ADDR_W-1:0] EVT_STATUS_ADDR = 12'h384;
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 12'h388;
  localparam logic [ADDR_W-1:0] SERIAL_IE_ADDR = 12'h38c;

  // control field positions
  localparam int CTL_IRQ_EN_BIT = 7;
  localparam int CTL_ENABLE_BIT = 6;
  localparam int CTL_ORDER_BIT = 5;
  localparam int CTL_ROLE_BIT = 4;
  localparam int CTL_CLOCK_IDLE_POLARITY_BIT = 3;
  localparam int CTL_CLOCK_SHIFT_PHASE_BIT = 2;
  localparam int CTL_RATE_HI_BIT = 1;
  localparam int CTL_RATE_LO_BIT = 0;
  // status field positions
  localparam int STS_DONE_BIT = 7;
  localparam int STS_COLL_BIT = 6;
  // event status / mask layout
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_COLL_BIT = 1;
  localparam int EVT_W = 2;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [EVT_W-1:0] EVT_MASK_RESET = 2'h0;
  localparam logic SERIAL_IE_RESET = 1'b0;

  // clock divisors for rate codes 00..11, and half periods in core clocks
  localparam int DIV_RATE0 = 4;
  localparam int DIV_RATE1 = 16;
  localparam int DIV_RATE2 = 64;
  localparam int DIV_RATE3 = 128;
  localparam logic [6:0] HALF_RATE0 = 7'(DIV_RATE0 / 2);
  localparam logic [6:0] HALF_RATE1 = 7'(DIV_RATE1 / 2);
  localparam logic [6:0] HALF_RATE2 = 7'(DIV_RATE2 / 2);
  localparam logic [6:0] HALF_RATE3 = 7'(DIV_RATE3 / 2);
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_MASTER, ST_SLAVE} smsp_state_e;

  typedef struct packed {
    logic sclk;
    logic ssN;
    logic mosi;
    logic miso;
  } smsp_pin_in_s;

  typedef struct packed {
    logic sclk;
    logic sclkOeN;
    logic mosi;
    logic mosiOeN;
    logic miso;
    logic misoOeN;
  } smsp_pin_out_s;
endpackage

//--- src/smsp_shifter.sv
// eight-bit full duplex shift register with selectable bit order
module smsp_shifter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [7:0] loadByte,
  input wire logic lsbFirst,
  input wire logic sampleEn,
  input wire logic driveEn,
  input wire logic inBit,
  output logic [7:0] byteOut,
  output logic txBit
);
  logic [7:0] shReg_q;
  logic txBit_q;
  logic head;
  logic firstBit;
  logic [7:0] shNext;

  assign head = lsbFirst ? shReg_q[0] : shReg_q[7];
  assign firstBit = lsbFirst ? loadByte[0] : loadByte[7];
  assign shNext = lsbFirst ? {inBit, shReg_q[7:1]} : {shReg_q[6:0], inBit};
  // with trailing-edge sampling the final sample lands in the same cycle as completion, so expose it early
  assign byteOut = sampleEn ? shNext : shReg_q;
  assign txBit = txBit_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      shReg_q <= 8'h00;
    end else if (load) begin
      shReg_q <= loadByte;
    end else if (sampleEn) begin
      shReg_q <= shNext;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txBit_q <= 1'b0;
    end else if (load) begin
      txBit_q <= firstBit;
    end else if (driveEn) begin
      txBit_q <= head;
    end
  end
endmodule

//--- dv/smsp_spi_peer.sv
// behavioural serial peer facing the port in master mode
module smsp_spi_peer (
  input wire logic core_clk,
  input wire logic load,
  input wire logic [7:0] txByte,
  input wire logic lsbFirst,
  input wire logic clock_idle_polarity,
  input wire logic clock_shift_phase,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev = 0;
  logic lead;
  int nLead = 9;
  int nTrail = 9;
  int idx;
  logic churn = 1'b0;
  initial rxByte = 8'h00;
  // leading edge is the one leaving the idle level
  assign lead = sclk != clock_idle_polarity;
  assign idx = clock_shift_phase ? nLead - 1 : nTrail;
  // next bit follows the edge count at once
  // a registered bit lags two core clocks, a whole half period at divide by four
  assign miso = (idx >= 0 && idx < 8) ? txByte[lsbFirst ? idx : 7 - idx] : churn;
  always @(posedge core_clk) begin
    prev <= sclk;
    if (load) begin
      nLead <= 0;
      nTrail <= 0;
    end else if (sclk != prev) begin
      if (lead) nLead <= nLead + 1;
      else nTrail <= nTrail + 1;
      // sample on the leading edge at phase 0, trailing at phase 1
      if (lead != clock_shift_phase) rxByte <= lsbFirst ? {mosi, rxByte[7:1]} : {rxByte[6:0], mosi};
    end
    // outside a byte the line churns
    churn <= ~churn;
  end
endmodule

//--- dv/smsp_port_properties.sv
// boundary checks of the serial port
module smsp_port_properties (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire smsp_pkg::smsp_pin_out_s pinOut,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read answer late or upper bits set");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after taking");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  aw_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while address pending");
  resp_code_a: assert property (
    s_axi_bvalid |-> s_axi_bresp == smsp_pkg::RESP_OKAY || s_axi_bresp == smsp_pkg::RESP_SLVERR)
    else $error("illegal write response code");
  master_pins_a: assert property (!pinOut.sclkOeN |-> !pinOut.mosiOeN && pinOut.misoOeN)
    else $error("clock driven without master pin set");
  half_period_a: assert property (!pinOut.sclkOeN && $changed(pinOut.sclk) |=> $stable(pinOut.sclk))
    else $error("serial clock half period below two cycles");
  clk_run_c: cover property (!pinOut.sclkOeN && $changed(pinOut.sclk));
  irq_c: cover property ($rose(irq));
  bad_addr_c: cover property (s_axi_bvalid && s_axi_bresp == smsp_pkg::RESP_SLVERR);
endmodule

bind smsp_port smsp_port_properties u_props (.*);

//--- dv/smsp_port_tb.sv
// randomised self-checking bench for the serial port
module smsp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0;
  logic rst = 1;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, peerMiso;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  smsp_pkg::smsp_pin_out_s pinOut;
  logic tbSclk = 0, tbSsN = 1, tbMosi = 0, load = 0, prevW = 0;
  logic [7:0] peerTx = 0, pctl = 0, peerRx, b;
  logic [15:0] rb;
  logic [7:0] tx = 0, sr = 0;
  int errors = 0, checked = 0, edges = 0, cyc = 0, t0 = 0, t1 = 0;
  wire sclkW = pinOut.sclkOeN ? tbSclk : pinOut.sclk;
  wire mosiW = pinOut.mosiOeN ? tbMosi : pinOut.mosi;
  wire smsp_pkg::smsp_pin_in_s pinIn = {sclkW, tbSsN, mosiW, peerMiso};

  smsp_port u_dut (.*);
  smsp_spi_peer u_peer (.core_clk(core_clk), .load(load), .txByte(peerTx), .lsbFirst(pctl[5]),
    .clock_idle_polarity(pctl[3]), .clock_shift_phase(pctl[2]), .sclk(sclkW), .mosi(mosiW), .miso(peerMiso), .rxByte(peerRx));

  always #4 core_clk = ~core_clk;

  // edge log of the driven clock, for count and rate
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    prevW <= sclkW;
    if (!pinOut.sclkOeN && sclkW !== prevW) begin
      if (edges == 0) t0 <= cyc;
      t1 <= cyc;
      edges <= edges + 1;
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    if (a == smsp_pkg::CONTROL_ADDR) pctl <= d;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    rs = s_axi_bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    rb = s_axi_rdata[15:0];
    rs = s_axi_rresp;
  endtask

  // polls status; bounded because a lost done flag must not hang
  task automatic waitDone;
    int n;
    n = 0;
    do begin
      rd(smsp_pkg::STATUS_ADDR);
      n++;
    end while (!rb[7] && n < 2000);
  endtask

  function automatic int halfOf(input logic [1:0] r);
    return r == 0 ? smsp_pkg::DIV_RATE0 / 2 : r == 1 ? smsp_pkg::DIV_RATE1 / 2 :
      r == 2 ? smsp_pkg::DIV_RATE2 / 2 : smsp_pkg::DIV_RATE3 / 2;
  endfunction

  task automatic mx(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] p;
    p = 8'($urandom);
    peerTx <= p;
    wr(smsp_pkg::CONTROL_ADDR, c);
    chk("clk drive", 0, pinOut.sclkOeN);
    load <= 1;
    @(posedge core_clk);
    load <= 0;
    edges = 0;
    wr(smsp_pkg::DATA_ADDR, d);
    waitDone;
    chk("status", 16'h80, rb);
    chk("peer rx", d, peerRx);
    chk("edges", 16, 16'(edges));
    chk("span", 16'(15 * halfOf(c[1:0])), 16'(t1 - t0));
    chk("idle clk", c[3], sclkW);
    rd(smsp_pkg::DATA_ADDR);
    chk("rx byte", p, rb);
    rd(smsp_pkg::STATUS_ADDR);
    chk("sticky", 16'h80, rb);
    wr(smsp_pkg::STATUS_ADDR, 8'h00);
    rd(smsp_pkg::STATUS_ADDR);
    chk("cleared", 0, rb);
  endtask

  // bench as external master, mode 0, msb first
  task automatic sb(input logic [7:0] d, input logic sel);
    tbSsN <= sel;
    for (int k = 7; k >= 0; k--) begin
      tbMosi <= d[k];
      repeat (4) @(posedge core_clk);
      sr = {sr[6:0], pinOut.miso};
      tbSclk <= 1;
      repeat (4) @(posedge core_clk);
      tbSclk <= 0;
    end
    repeat (4) @(posedge core_clk);
    tbSsN <= 1;
  endtask

  task automatic conclude;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a full run takes far less than this span
  initial begin
    #500us;
    errors++;
    conclude;
  end

  initial begin
    void'($urandom(86));
    repeat (8) @(posedge core_clk);
    rst <= 0;
    rd(smsp_pkg::CONTROL_ADDR);
    chk("control", smsp_pkg::CONTROL_RESET, rb);
    rd(smsp_pkg::STATUS_ADDR);
    chk("status", 0, rb);
    chk("pins off", 3'h7, {pinOut.sclkOeN, pinOut.mosiOeN, pinOut.misoOeN});
    chk("irq", 0, irq);
    rd(12'h004);
    chk("bad read", smsp_pkg::RESP_SLVERR, rs);
    wr(12'h008, 8'h5a);
    chk("bad write", smsp_pkg::RESP_SLVERR, rs);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      b = i == 0 ? 8'h81 : 8'($urandom);
      mx({2'h1, 1'($urandom), 1'b1, i[2], i[3], i[1:0]}, b);
    end
    $display("test master done");
    wr(smsp_pkg::EVT_MASK_ADDR, 8'h03);
    wr(smsp_pkg::SERIAL_IE_ADDR, 8'h01);
    wr(smsp_pkg::CONTROL_ADDR, 8'hd3);
    wr(smsp_pkg::DATA_ADDR, 8'h3c);
    wr(smsp_pkg::DATA_ADDR, 8'hc3);
    waitDone;
    chk("collision", 16'hc0, rb);
    chk("peer kept", 8'h3c, peerRx);
    @(posedge core_clk);
    chk("irq on", 1, irq);
    wr(smsp_pkg::SERIAL_IE_ADDR, 8'h00);
    @(posedge core_clk);
    chk("irq ie off", 0, irq);
    wr(smsp_pkg::SERIAL_IE_ADDR, 8'h01);
    wr(smsp_pkg::CONTROL_ADDR, 8'h53);
    @(posedge core_clk);
    chk("irq ctl off", 0, irq);
    wr(smsp_pkg::CONTROL_ADDR, 8'hd3);
    rd(smsp_pkg::EVT_STATUS_ADDR);
    chk("events", 16'h3, rb);
    @(posedge core_clk);
    chk("irq read clr", 0, irq);
    wr(smsp_pkg::STATUS_ADDR, 8'h00);
    $display("test collision done");
    wr(smsp_pkg::CONTROL_ADDR, {6'h10, 2'($urandom)});
    chk("slave clk pin", 1, pinOut.sclkOeN);
    sb(8'ha5, 1'b1);
    rd(smsp_pkg::STATUS_ADDR);
    chk("unselected", 0, rb);
    tx = 8'($urandom);
    wr(smsp_pkg::DATA_ADDR, tx);
    b = 8'($urandom);
    sb(b, 1'b0);
    rd(smsp_pkg::STATUS_ADDR);
    chk("slave done", 16'h80, rb);
    rd(smsp_pkg::DATA_ADDR);
    chk("slave rx", b, rb);
    chk("slave tx", tx, sr);
    $display("test slave done");
    conclude;
  end
endmodule
